// File: inc/msc_pkg.sv
package msc_pkg;

   // -----------------------------------------------------------------
   // Register map and field layout
   // -----------------------------------------------------------------
   localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
   localparam logic [6:0] ADDR_HW_CONFIG   = 7'h02;
   localparam logic [7:0] MSC_POR_VALUE    = 8'h00;
   localparam int MS_MODE_HI    = 7;
   localparam int MS_MODE_LO    = 6;
   localparam int MS_AUX_ON     = 5;
   localparam int MS_POL_HI     = 4;
   localparam int MS_POL_LO     = 3;
   localparam int MS_OV_ESC     = 2;
   localparam int MS_RT_HI      = 1;
   localparam int MS_RT_LO      = 0;
   localparam int HW_AUX_VSEL   = 7;
   localparam int HW_RST_MASK   = 6;
   localparam int HW_FO_SW      = 5;
   localparam int HW_AUX_KEEPUV = 4;
   localparam int HW_AUX_LS     = 3;
   localparam int HW_RSVD       = 2;
   localparam int HW_STOP_LS    = 1;
   localparam int HW_WD_FIRST   = 0;
   // Bits that survive a restart (set = kept) and a soft reset, then the writable config bits
   localparam logic [7:0] MS_RESTART_KEEP = 8'h23;
   localparam logic [7:0] HW_RESTART_KEEP = 8'hD9;
   localparam logic [7:0] HW_SOFT_KEEP    = 8'h88;
   localparam logic [7:0] HW_WRITE_MASK   = 8'hFB;

   // -----------------------------------------------------------------
   // Frame and timing
   // -----------------------------------------------------------------
   localparam int         FRAME_BITS      = 16;
   localparam logic [4:0] FRAME_LEN       = 5'h10;
   localparam logic [4:0] ADDR_BYTE_DONE  = 5'h08;
   localparam int         CLK_PERIOD_PS   = 10000;
   localparam int         SOFT_RST_PULSE_NS = 2000;
   localparam int         SOFT_RST_CYCLES =
      (SOFT_RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      MSC_NORMAL = 2'b00,
      MSC_SLEEP  = 2'b01,
      MSC_STOP   = 2'b10,
      MSC_SOFTRST = 2'b11
   } msc_mode_t;

   // Events and levels from the surrounding supply and supervision logic
   typedef struct packed {
      logic restart_entry;
      logic overtemperature_event;
      logic main_ov_detect;
      logic main_ov_flag_clear;
      logic supply_undervoltage;
      logic failure_event;
      logic failure_status_clear;
      logic watchdog_fail;
      logic fail_safe;
      logic high_peak_select;
   } msc_hw_in_t;

   // Controls handed to the regulators and the supervision logic
   typedef struct packed {
      msc_mode_t  mode;
      logic       aux_regulator_enable;
      logic       aux_voltage_select;
      logic       aux_load_sharing;
      logic       second_regulator_on;
      logic [1:0] reset_threshold_select;
      logic       main_overvoltage_flag;
      logic       ov_escalate;
      logic       wd_escalate;
      logic       failure_outputs;
   } msc_supply_out_t;

endpackage

// File: rtl/msc_regs.sv
`timescale 1ns/1ps
// Overview of operation
// R1: Mode field bits 7:6 select normal, sleep, stop, or soft reset.
// R2: Soft reset pulls reset output low unless pulse mask bit 6 set.
// R3: Mode register bit 5 enables auxiliary regulator independently.
// R4: Bits 4:3 set second regulator policy across modes.
// R5: Overvoltage always sets flag; bit 2 also requests escalation.
// R6: Bits 1:0 choose one of four main reset thresholds.
// R7: Writing sleep while in stop leaves the mode in stop.
// R8: Entering restart loads mode field with normal.
// R9: Restart and overtemperature clear second regulator policy to off.
// R10: Write frame returns previously programmed value, not written value.
// R11: Config bit 7 selects auxiliary voltage: main voltage or fixed.
// R12: Config bit 5 drives failure outputs under software control.
// R13: Config bit 4 keeps auxiliary regulator on at supply undervoltage.
// R14: Config bit 3 selects stand-alone or load-sharing auxiliary operation.
// R15: Config bit 1 enables load sharing in stop mode.
// R16: Config bit 0 escalates on first watchdog failure, else second.
// R17: Reserved config bit 2 always reads zero.
// R18: Failure-event outputs release only when failure status clears.
// R19: Restart clears software failure-output bit and its outputs.
// R20: Soft reset keeps auxiliary voltage and load-sharing bits.
// R21: Power-on reset zeroes the whole config register.
// R22: Stop load sharing also needs the high active peak setting.
// R23: Frames are 16 bits: address, access bit, then data byte.
// R24: Master sets frame bit 7 to write, clears it to read.
// R25: Writes commit only after full 16-bit frame at chip select release.
module msc_regs
(
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic                     spi_sclk,
   input  wire logic                     spi_csn,
   input  wire logic                     spi_mosi,
   output logic                          spi_miso,
   output logic                          spi_miso_oe,
   input  wire msc_pkg::msc_hw_in_t      hw_in,
   output msc_pkg::msc_supply_out_t      supply_out,
   output logic                          reset_output_n
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  sclk_sync;
      logic [2:0]  csn_sync;
      logic [1:0]  mosi_sync;
      logic [15:0] rx;
      logic [8:0]  tx;
      logic [4:0]  bit_count;
      logic [7:0]  mode_supply_control;
      logic [7:0]  hardware_config_control;
      logic        ov_flag;
      logic        ov_escalate;
      logic        wd_escalate;
      logic        wd_first_seen;
      logic        fail_latched;
      logic [15:0] rst_pulse_count;
   } msc_state_t;

   msc_state_t cur;
   msc_state_t next_cur;

   // Register readback with the reserved bit forced low
   function automatic logic [7:0] msc_read(input logic [6:0] addr,
                                           input msc_state_t s);
      logic [7:0] value;
      value = 8'h00;
      if (addr == msc_pkg::ADDR_MODE_SUPPLY)
         value = s.mode_supply_control;
      else if (addr == msc_pkg::ADDR_HW_CONFIG)
         value = s.hardware_config_control & msc_pkg::HW_WRITE_MASK; // R17
      return value;
   endfunction

   logic sclk_rise;
   logic sclk_fall;
   logic cs_active;
   logic cs_release;
   logic frame_ok;

   // ----------------------------------------------------------------
   // Link edge detection on synchronised pins
   // ----------------------------------------------------------------
   // Only stages 1 and 2 are examined; stage 0 is the metastable one
   assign sclk_rise  = cur.sclk_sync[1] & ~cur.sclk_sync[2];
   assign sclk_fall  = ~cur.sclk_sync[1] & cur.sclk_sync[2];
   assign cs_active  = ~cur.csn_sync[1];
   assign cs_release = cur.csn_sync[1] & ~cur.csn_sync[2];
   // Aborted or overlong frames are dropped whole
   assign frame_ok   = cs_release && (cur.bit_count == msc_pkg::FRAME_LEN); // R23 R25

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [7:0]  wdata;
      logic [1:0]  new_mode;
      logic        soft_reset;
      logic        mask_pulse;
      wdata      = cur.rx[15:8];
      new_mode   = 2'b00;
      soft_reset = 1'b0;
      mask_pulse = cur.hardware_config_control[msc_pkg::HW_RST_MASK];
      next_cur   = cur;

      next_cur.sclk_sync = {cur.sclk_sync[1:0], spi_sclk};
      next_cur.csn_sync  = {cur.csn_sync[1:0], spi_csn};
      next_cur.mosi_sync = {cur.mosi_sync[0], spi_mosi};

      // Shifter: LSB first, sample on rising, change on falling SCLK
      if (!cs_active)
      begin
         next_cur.bit_count = 5'h00;
         next_cur.tx        = 9'h000;
      end
      else
      begin
         if (sclk_rise)
         begin
            next_cur.rx = {cur.mosi_sync[1], cur.rx[15:1]};
            if (cur.bit_count != 5'h1F)
               next_cur.bit_count = cur.bit_count + 5'h01;
            // Old content is loaded here, so a write echoes the prior value
            if (cur.bit_count + 5'h01 == msc_pkg::ADDR_BYTE_DONE)
               next_cur.tx = {msc_read(cur.rx[15:9], cur), 1'b0}; // R10
         end
         if (sclk_fall && cur.bit_count != 5'h00)
            next_cur.tx = {1'b0, cur.tx[8:1]};
      end

      // Commit a write at chip select release
      if (frame_ok && cur.rx[7]) // R24 R25
      begin
         if (cur.rx[6:0] == msc_pkg::ADDR_MODE_SUPPLY)
         begin
            new_mode = wdata[7:6];
            if (new_mode == msc_pkg::MSC_SOFTRST) // R1
               soft_reset = 1'b1;
            else
            begin
               // Stop cannot go straight to sleep; keep stop
               if (cur.mode_supply_control[7:6] == msc_pkg::MSC_STOP &&
                   new_mode == msc_pkg::MSC_SLEEP)
                  new_mode = msc_pkg::MSC_STOP; // R7
               next_cur.mode_supply_control = {new_mode, wdata[5:0]}; // R1 R3 R4 R6
            end
         end
         else if (cur.rx[6:0] == msc_pkg::ADDR_HW_CONFIG)
            next_cur.hardware_config_control = wdata & msc_pkg::HW_WRITE_MASK; // R17
      end

      // Soft reset: both registers to soft value, config keeps two bits
      if (soft_reset)
      begin
         next_cur.mode_supply_control = msc_pkg::MSC_POR_VALUE;
         next_cur.hardware_config_control =
            cur.hardware_config_control & msc_pkg::HW_SOFT_KEEP; // R20
         if (!mask_pulse)
            next_cur.rst_pulse_count = 16'(msc_pkg::SOFT_RST_CYCLES); // R2
      end
      else if (cur.rst_pulse_count != 16'h0000)
         next_cur.rst_pulse_count = cur.rst_pulse_count - 16'h0001;

      // Overtemperature turns the second regulator off
      if (hw_in.overtemperature_event)
         next_cur.mode_supply_control[4:3] = 2'b00; // R9

      // Restart has priority over any register write
      if (hw_in.restart_entry)
      begin
         next_cur.mode_supply_control =
            cur.mode_supply_control & msc_pkg::MS_RESTART_KEEP; // R8 R9
         next_cur.hardware_config_control =
            cur.hardware_config_control & msc_pkg::HW_RESTART_KEEP; // R19
         next_cur.wd_first_seen = 1'b0;
      end

      // Overvoltage flag: set wins over clear
      if (hw_in.main_ov_detect)
         next_cur.ov_flag = 1'b1; // R5
      else if (hw_in.main_ov_flag_clear)
         next_cur.ov_flag = 1'b0;
      next_cur.ov_escalate =
         hw_in.main_ov_detect & cur.mode_supply_control[msc_pkg::MS_OV_ESC]; // R5

      // Watchdog escalation on first or second trigger failure
      next_cur.wd_escalate = 1'b0;
      if (hw_in.watchdog_fail && !hw_in.restart_entry)
      begin
         if (cur.hardware_config_control[msc_pkg::HW_WD_FIRST] || cur.wd_first_seen) // R16
            next_cur.wd_escalate = 1'b1;
         next_cur.wd_first_seen = 1'b1;
      end

      // Event-driven failure outputs; set wins over clear
      if (hw_in.failure_event)
         next_cur.fail_latched = 1'b1; // R18
      else if (hw_in.failure_status_clear)
         next_cur.fail_latched = 1'b0; // R18
   end

   // ----------------------------------------------------------------
   // State register; power-on reset zeroes both registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cur                         <= '0;
         cur.sclk_sync               <= 3'h0;
         cur.csn_sync                <= 3'h7;
         cur.mode_supply_control     <= msc_pkg::MSC_POR_VALUE;
         cur.hardware_config_control <= msc_pkg::MSC_POR_VALUE; // R21
      end
      else
         cur <= next_cur;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic [7:0] ms;
   logic [7:0] hw;
   logic       in_stop;
   assign ms      = cur.mode_supply_control;
   assign hw      = cur.hardware_config_control;
   assign in_stop = (ms[7:6] == msc_pkg::MSC_STOP);

   // Gated by select: an aborted frame may leave a data bit in the shifter
   assign spi_miso       = cur.tx[0] & cs_active;
   assign spi_miso_oe    = cs_active;
   assign reset_output_n = (cur.rst_pulse_count == 16'h0000); // R2

   // Regulator controls decoded from the register fields
   always_comb
   begin
      supply_out.mode = msc_pkg::msc_mode_t'(ms[7:6]); // R1
      // Undervoltage shutdown unless the keep-on bit is set
      supply_out.aux_regulator_enable = ms[msc_pkg::MS_AUX_ON] &
         ~(hw_in.supply_undervoltage & ~hw[msc_pkg::HW_AUX_KEEPUV]); // R3 R13
      supply_out.aux_voltage_select = hw[msc_pkg::HW_AUX_VSEL]; // R11
      // In stop, sharing needs both the stop enable and high peak setting
      supply_out.aux_load_sharing = hw[msc_pkg::HW_AUX_LS] &
         (~in_stop | (hw[msc_pkg::HW_STOP_LS] & hw_in.high_peak_select)); // R14 R15 R22
      case (ms[4:3]) // R4
         2'b01:   supply_out.second_regulator_on = (ms[7:6] == msc_pkg::MSC_NORMAL);
         2'b10:   supply_out.second_regulator_on = (ms[7:6] == msc_pkg::MSC_NORMAL) | in_stop;
         2'b11:   supply_out.second_regulator_on = ~hw_in.fail_safe;
         default: supply_out.second_regulator_on = 1'b0;
      endcase
      supply_out.reset_threshold_select = ms[1:0]; // R6
      supply_out.main_overvoltage_flag  = cur.ov_flag;
      supply_out.ov_escalate            = cur.ov_escalate;
      supply_out.wd_escalate            = cur.wd_escalate;
      // Clearing the software bit never releases an event-driven output
      supply_out.failure_outputs = hw[msc_pkg::HW_FO_SW] | cur.fail_latched; // R12 R18
   end

endmodule

// File: verification/msc_regs_chk.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Port checker
// ---------------------------------------------
module msc_regs_chk
(
   input wire logic                     clock,
   input wire logic                     rst,
   input wire logic                     spi_sclk,
   input wire logic                     spi_csn,
   input wire logic                     spi_mosi,
   input wire logic                     spi_miso,
   input wire logic                     spi_miso_oe,
   input wire msc_pkg::msc_hw_in_t      hw_in,
   input wire msc_pkg::msc_supply_out_t supply_out,
   input wire logic                     reset_output_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   int low_cnt;

   // Length of the current low phase of the reset output
   always_ff @(posedge clock)
      low_cnt <= (rst || reset_output_n) ? 0 : low_cnt + 1;

   AST_RST_CLEAR: assert property ($past(rst) |-> supply_out.mode == msc_pkg::MSC_NORMAL
      && reset_output_n && !supply_out.aux_voltage_select) else $error("state after reset");
   AST_PULSE_LEN: assert property ($rose(reset_output_n) && !$past(rst)
      |-> low_cnt == msc_pkg::SOFT_RST_CYCLES) else $error("reset pulse length");
   AST_OV_FLAG: assert property (hw_in.main_ov_detect |=> supply_out.main_overvoltage_flag)
      else $error("overvoltage flag not set");
   AST_OV_ESC: assert property (supply_out.ov_escalate |-> $past(hw_in.main_ov_detect))
      else $error("escalation without overvoltage");
   AST_WD_ESC: assert property (supply_out.wd_escalate |-> $past(hw_in.watchdog_fail))
      else $error("escalation without watchdog failure");
   AST_STOP_SLEEP: assert property (supply_out.mode == msc_pkg::MSC_STOP
      |=> supply_out.mode != msc_pkg::MSC_SLEEP) else $error("stop went to sleep");
   AST_RESTART_NORM: assert property (hw_in.restart_entry
      |=> supply_out.mode == msc_pkg::MSC_NORMAL) else $error("restart mode");
   AST_POLICY_CLR: assert property (hw_in.restart_entry || hw_in.overtemperature_event
      |=> !supply_out.second_regulator_on) else $error("second regulator kept on");
   AST_FAIL_SET: assert property (hw_in.failure_event |=> supply_out.failure_outputs)
      else $error("failure outputs not set");
   AST_LS_STOP: assert property (supply_out.aux_load_sharing
      && supply_out.mode == msc_pkg::MSC_STOP |-> hw_in.high_peak_select)
      else $error("stop load sharing");
   AST_MISO_IDLE: assert property (!spi_miso_oe |-> !spi_miso)
      else $error("data out outside frame");
endmodule

bind msc_regs msc_regs_chk i_msc_regs_chk (.clock(clock), .rst(rst), .spi_sclk(spi_sclk),
   .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
   .hw_in(hw_in), .supply_out(supply_out), .reset_output_n(reset_output_n));

// File: verification/msc_regs_tb.sv
`timescale 1ns/1ps
module msc_regs_tb;
   // ---------------------------------------------
   // Signals and expected register images
   // ---------------------------------------------
   localparam msc_pkg::msc_hw_in_t P_RS = 10'h200;
   localparam msc_pkg::msc_hw_in_t P_OT = 10'h100;
   localparam msc_pkg::msc_hw_in_t P_OV = 10'h080;
   localparam msc_pkg::msc_hw_in_t P_OC = 10'h040;
   localparam msc_pkg::msc_hw_in_t P_FE = 10'h010;
   localparam msc_pkg::msc_hw_in_t P_FC = 10'h008;
   localparam msc_pkg::msc_hw_in_t P_WD = 10'h004;
   logic                     clock = 1'b0;
   logic                     rst   = 1'b1;
   logic                     sclk;
   logic                     csn;
   logic                     mosi;
   logic                     miso;
   logic                     oe;
   logic                     rstn_o;
   msc_pkg::msc_hw_in_t      hw    = '0;
   msc_pkg::msc_supply_out_t so;
   logic [7:0]               ms    = msc_pkg::MSC_POR_VALUE;
   logic [7:0]               hv    = msc_pkg::MSC_POR_VALUE;
   int                       error_cnt = 0;
   int                       cmp_count = 0;
   int                       cyc   = 0;

   msc_regs i_msc_regs (.clock(clock), .rst(rst), .spi_sclk(sclk), .spi_csn(csn),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe), .hw_in(hw), .supply_out(so),
      .reset_output_n(rstn_o));
   msc_spi_master i_msc_spi_master (.spi_sclk(sclk), .spi_csn(csn), .spi_mosi(mosi),
      .spi_miso(miso));

   // Clock and hang guard
   always #5 clock = ~clock;
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic complete_run();
      $display("errors %0d of %0d compares", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic ok, input string what);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   // Write frame; the answer is the value held before it
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input int nb);
      logic [7:0] rx;
      logic [7:0] old;
      old = (a == msc_pkg::ADDR_MODE_SUPPLY) ? ms : (a == msc_pkg::ADDR_HW_CONFIG) ? hv : 8'h00;
      i_msc_spi_master.xfer({d, 1'b1, a}, nb, rx);
      @(negedge clock);
      chk(nb < 16 || rx === old, "write answer");
      if (nb == 16 && a == msc_pkg::ADDR_MODE_SUPPLY && d[7:6] == 2'b11)
      begin
         chk(rstn_o === hv[6], "soft reset output");
         ms = 8'h00;
         hv = hv & 8'h88; // Soft reset keeps voltage select and load sharing
         repeat (220) @(negedge clock);
      end
      else if (nb == 16 && a == msc_pkg::ADDR_MODE_SUPPLY)
         ms = (d[7:6] == 2'b01 && ms[7:6] == 2'b10) ? {2'b10, d[5:0]} : d;
      else if (nb == 16 && a == msc_pkg::ADDR_HW_CONFIG)
         hv = d & 8'hFB;
   endtask

   // Read frame with a random data byte that must be ignored
   task automatic rd(input logic [6:0] a);
      logic [7:0] rx;
      logic [7:0] ex;
      ex = (a == msc_pkg::ADDR_MODE_SUPPLY) ? ms : (a == msc_pkg::ADDR_HW_CONFIG) ? hv : 8'h00;
      i_msc_spi_master.xfer({8'($urandom), 1'b0, a}, 16, rx);
      @(negedge clock);
      chk(rx === ex, "read value");
      chk(oe === 1'b0 && miso === 1'b0, "link idle");
   endtask

   // A spare edge first, so back-to-back pulses never touch hw twice in one step
   task automatic pulse(input msc_pkg::msc_hw_in_t m);
      @(negedge clock);
      hw = msc_pkg::msc_hw_in_t'(hw | m);
      @(negedge clock);
      hw = msc_pkg::msc_hw_in_t'(hw & ~m);
   endtask

   // Decoded outputs against the register images
   task automatic outs();
      logic on;
      on = ms[4:3] == 2'b11 ? !hw.fail_safe : ms[4:3] == 2'b10 ? !ms[6] : ms[4:3] == 2'b01 ?
         ms[7:6] == 2'b00 : 1'b0;
      chk(so.second_regulator_on === on, "second regulator");
      chk(so.mode === ms[7:6] && so.reset_threshold_select === ms[1:0], "mode");
      chk(so.aux_regulator_enable === (ms[5] & (!hw.supply_undervoltage | hv[4])), "aux");
      chk(so.aux_voltage_select === hv[7] && so.failure_outputs === hv[5], "cfg");
      chk(so.aux_load_sharing === (hv[3] & (ms[7:6] != 2'b10 | (hv[1] & hw.high_peak_select))),
         "load sharing");
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      logic [6:0] a;
      void'($urandom(63549));
      repeat (6) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
      rd(7'h01);
      rd(7'h02);
      for (int i = 0; i < 40; i++)
      begin
         {hw.supply_undervoltage, hw.fail_safe, hw.high_peak_select} = 3'($urandom);
         a = 7'(1 + $urandom % 2);
         wr(a, 8'($urandom), 16);
         outs();
         rd(a);
      end
      wr(7'h02, 8'h00, 16);
      wr(7'h01, 8'h80, 16);
      wr(7'h01, 8'h40, 16);
      rd(7'h01);
      for (int m = 0; m < 2; m++)
      begin
         wr(7'h02, {1'b1, 1'(m), 6'h0B}, 16);
         wr(7'h01, 8'hC0, 16);
         rd(7'h02);
      end
      wr(7'h05, 8'($urandom), 16);
      rd(7'h05);
      wr(7'h01, 8'($urandom), 15);
      rd(7'h01);
      for (int e = 0; e < 2; e++)
      begin
         wr(7'h01, {5'h00, 1'(e), 2'b00}, 16);
         pulse(P_OV);
         chk(so.main_overvoltage_flag === 1'b1 && so.ov_escalate === 1'(e), "overvoltage");
      end
      pulse(msc_pkg::msc_hw_in_t'(P_OV | P_OC));
      chk(so.main_overvoltage_flag === 1'b1, "overvoltage set beats clear");
      pulse(P_OC);
      chk(so.main_overvoltage_flag === 1'b0, "overvoltage cleared");
      wr(7'h01, 8'hBF, 16);
      wr(7'h02, 8'hFB, 16);
      pulse(P_RS);
      ms = ms & 8'h23;
      hv = hv & 8'hD9;
      outs();
      rd(7'h01);
      rd(7'h02);
      pulse(P_WD);
      chk(so.wd_escalate === 1'b1, "first failure");
      wr(7'h02, 8'h00, 16);
      pulse(P_RS);
      ms = ms & 8'h23;
      pulse(P_WD);
      chk(so.wd_escalate === 1'b0, "one failure");
      pulse(P_WD);
      chk(so.wd_escalate === 1'b1, "second failure");
      wr(7'h01, 8'h18, 16);
      pulse(P_OT);
      ms[4:3] = 2'b00;
      outs();
      pulse(P_FE);
      wr(7'h02, 8'h20, 16);
      wr(7'h02, 8'h00, 16);
      chk(so.failure_outputs === 1'b1, "failure held");
      pulse(P_FC);
      chk(so.failure_outputs === 1'b0, "failure released");
      pulse(msc_pkg::msc_hw_in_t'(P_FE | P_FC));
      chk(so.failure_outputs === 1'b1, "failure set beats clear");
      pulse(P_FC);
      chk(so.failure_outputs === 1'b0, "failure cleared again");
      complete_run();
   end
endmodule

// File: verification/msc_spi_master.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Serial master model for the register link
// ---------------------------------------------
module msc_spi_master
(
   output logic      spi_sclk,
   output logic      spi_csn,
   output logic      spi_mosi,
   input  wire logic spi_miso
);
   // Idle: clock low, deselected
   initial
   begin
      spi_sclk = 1'b0;
      spi_csn  = 1'b1;
      spi_mosi = 1'b0;
   end

   // One frame, LSB first; nb below 16 gives an aborted frame
   // Half periods of 63 and 62 ns keep every edge off the system clock edges
   task automatic xfer(input logic [15:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      #1;
      spi_csn = 1'b0;
      for (int i = 0; i < nb; i++)
      begin
         spi_mosi = tx[i];
         #63;
         if (i > 7)
            rx[i-8] = spi_miso;
         spi_sclk = 1'b1;
         #62;
         spi_sclk = 1'b0;
      end
      #63;
      spi_csn  = 1'b1;
      spi_mosi = ~spi_mosi; // Released line must not hold a stale bit
      #200;
   endtask
endmodule
